// ===== design/cfgp_defs.svh
// Constants for the configuration protection and identification block.
// Assumes a 22-bit programming address space, with one byte per address.
`ifndef CFGP_DEFS_SVH
`define CFGP_DEFS_SVH

// Address width of the programming space
`define CFGP_AW 22

// Byte addresses of the configuration and identification locations
`define CFGP_ADDR_CFG4L 22'h300006
`define CFGP_ADDR_CFG5L 22'h300008
`define CFGP_ADDR_CFG5H 22'h300009
`define CFGP_ADDR_CFG6L 22'h30000A
`define CFGP_ADDR_CFG6H 22'h30000B
`define CFGP_ADDR_CFG7L 22'h30000C
`define CFGP_ADDR_CFG7H 22'h30000D
`define CFGP_ADDR_ID_LO 22'h3FFFFE
`define CFGP_ADDR_ID_HI 22'h3FFFFF

// Erased (factory) value of every configuration byte
`define CFGP_ERASED 8'hFF
// Answer to an unmapped read
`define CFGP_UNMAPPED 8'h00

// Field positions in the low-voltage and boot-size byte
`define CFGP_LV_EN_BIT 2
`define CFGP_BOOT_SIZE_LSB 4
`define CFGP_BOOT_SIZE_MASK 8'h30
// Code protect bits
`define CFGP_BLK0_CODE_BIT 0
`define CFGP_BOOT_CODE_BIT 6
// Special write locks
`define CFGP_CFG_WLOCK_BIT 5
`define CFGP_BOOT_WLOCK_BIT 6
`define CFGP_DATA_WLOCK_BIT 7
// Boot table read lock
`define CFGP_BOOT_RLOCK_BIT 6

// Identification byte layout
`define CFGP_PART_MSB 7
`define CFGP_PART_LSB 5
`define CFGP_REV_MSB 4
`define CFGP_REV_LSB 0
`define CFGP_TOP_REV_BIT 4

// Code memory geometry
`define CFGP_BOOT_UNIT 22'h000800
`define CFGP_BLOCK_SIZE 22'h004000
`define CFGP_MAX_BLOCKS 6

`endif

// ===== design/cfgp_pkg.sv
// Types shared by the configuration protection block.
// Assumes cfgp_defs.svh supplies the numeric constants.
package cfgp_pkg;

   // Programming entry mode, Gray coded along run -> low -> high voltage
   typedef enum logic [1:0] {
      CFGP_RUN = 2'b00,
      CFGP_LV_PROG = 2'b01,
      CFGP_HV_PROG = 2'b11
   } cfgp_mode_t;

   // Programming space address
   typedef logic [21:0] cfgp_addr_t;

endpackage

// ===== design/cfgp_block_guard.sv
// Range check and access gate for one code memory block.
// Assumes bounds are stable while an access request is presented.
`timescale 1ns/1ps

module cfgp_block_guard #(
   parameter int AW = 22
) (
   // Access under test
   input wire logic [AW-1:0] i_addr,
   input wire logic [AW-1:0] i_exec_addr,
   // Block bounds, inclusive
   input wire logic [AW-1:0] i_lo,
   input wire logic [AW-1:0] i_hi,
   // Lock bits, one means open
   input wire logic i_wr_open,
   input wire logic i_rd_open,
   // Verdicts
   output logic o_hit,
   output logic o_wr_ok,
   output logic o_rd_ok
);

   logic exec_in;

   // Target and executing code range checks
   assign o_hit = (i_addr >= i_lo) && (i_addr <= i_hi);
   assign exec_in = (i_exec_addr >= i_lo) && (i_exec_addr <= i_hi);

   // Write open only when the lock bit is one
   assign o_wr_ok = o_hit && i_wr_open;
   // Table read from inside the block is always allowed
   assign o_rd_ok = o_hit && (i_rd_open || exec_in);

endmodule

// ===== design/cfgp_config_protect.sv
// Configuration protection, identification word and programming entry logic.
// Assumes one 20 MHz clock; programmer requests are synchronous single-cycle
// strobes; core memory requests are held until answered combinationally.
`timescale 1ns/1ps
`include "cfgp_defs.svh"

// What this block does
// - Identification word at top address, readable
// - Identification readable regardless of any protection
// - Low byte: part code, revision; high: family
// - Per-block write lock, zero blocks writes
// - Data memory write lock, zero refuses writes
// - Boot block write lock, zero refuses writes
// - Config write lock, zero refuses config writes
// - Per-block table read lock against other blocks
// - Blocks four, five only if present
// - Boot size frozen once boot/block0 protected
// - Low-voltage enable erased value is one
// - Enable zero makes entry pin ordinary I/O
// - Low-voltage enable writable only in high-voltage
// - Enable zero ignores low-voltage entry
// - High-voltage entry always honoured
// - Entry pin dedicated during low-voltage mode
module cfgp_config_protect #(
   parameter int NUM_BLOCKS = 4,
   parameter logic [7:0] FAMILY_CODE = 8'h5A,  // Arbitrary value
   parameter logic [2:0] PART_CODE = 3'h5,     // Arbitrary value
   parameter logic [4:0] REV_CODE = 5'h01      // Arbitrary value
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Programming entry detection
   input wire logic i_high_entry_voltage,
   input wire logic i_prog_entry_pin,
   // Programmer access to configuration and identification
   input wire logic i_cfg_we,
   input wire logic i_cfg_re,
   input wire logic [21:0] i_cfg_addr,
   input wire logic [7:0] i_cfg_wdata,
   output logic [7:0] o_cfg_rdata,
   output logic o_cfg_rvalid,
   output logic o_cfg_wack,
   output logic o_cfg_wrefused,
   // Code memory write and table read checks
   input wire logic i_code_wr_req,
   input wire logic i_code_rd_req,
   input wire logic [21:0] i_code_addr,
   input wire logic [21:0] i_exec_addr,
   output logic o_code_wr_ok,
   output logic o_code_rd_ok,
   // Data memory write check
   input wire logic i_data_wr_req,
   output logic o_data_wr_ok,
   // Programming state
   output logic o_prog_active,
   output logic o_prog_high_voltage,
   output logic o_prog_entry_pin_gpio,
   output logic [2:0] o_boot_size_field
);

   // Guard count includes the boot block
   localparam int NG = NUM_BLOCKS + 1;
   // Lock byte bits of the blocks that exist
   localparam logic [7:0] BLK_MASK = 8'((1 << NUM_BLOCKS) - 1);

   // Stored configuration bytes
   // Code protect bytes only feed the boot size freeze here
   logic [7:0] debug_lvp_config_low_q;
   logic [7:0] code_protect_low_q;
   logic [7:0] code_protect_high_q;
   logic [7:0] write_protect_blocks_q;
   logic [7:0] write_protect_special_q;
   logic [7:0] table_read_protect_blocks_q;
   logic [7:0] table_read_protect_special_q;

   // Programmer port state
   logic [7:0] cfg_rdata_q;
   logic [7:0] cfg_rdata_d;
   logic cfg_rvalid_q;
   logic cfg_wack_q;
   logic cfg_wrefused_q;

   // Mode machine
   cfgp_pkg::cfgp_mode_t mode_q;
   cfgp_pkg::cfgp_mode_t mode_d;

   // Derived protection view
   logic low_voltage_prog_enable;
   logic [1:0] boot_size_field;
   logic boot_size_locked;
   logic config_write_lock;
   logic data_mem_write_lock;
   logic boot_write_lock;
   logic boot_read_lock;
   logic boot_code_protect;
   logic block0_code_protect;
   logic cfg_write_allowed;
   logic [7:0] part_revision_byte;
   logic [7:0] part_family_byte;
   logic [7:0] wr_lock_eff;
   logic [7:0] rd_lock_eff;
   logic [21:0] boot_hi;

   // Guard arrays, index 0 is the boot block
   logic [21:0] grd_lo [NG];
   logic [21:0] grd_hi [NG];
   logic [NG-1:0] grd_wr_open;
   logic [NG-1:0] grd_rd_open;
   logic [NG-1:0] grd_hit;
   logic [NG-1:0] grd_wr_ok;
   logic [NG-1:0] grd_rd_ok;

   // Entry enable and boot size fields
   assign low_voltage_prog_enable = debug_lvp_config_low_q[`CFGP_LV_EN_BIT];
   assign boot_size_field = debug_lvp_config_low_q[`CFGP_BOOT_SIZE_LSB +: 2];

   // Special write locks, one means open
   assign config_write_lock = write_protect_special_q[`CFGP_CFG_WLOCK_BIT];
   assign data_mem_write_lock = write_protect_special_q[`CFGP_DATA_WLOCK_BIT];
   assign boot_write_lock = write_protect_special_q[`CFGP_BOOT_WLOCK_BIT];

   // Boot read lock and code protect bits, one means open
   assign boot_read_lock = table_read_protect_special_q[`CFGP_BOOT_RLOCK_BIT];
   assign boot_code_protect = code_protect_high_q[`CFGP_BOOT_CODE_BIT];
   assign block0_code_protect = code_protect_low_q[`CFGP_BLK0_CODE_BIT];

   // Absent blocks read as unlocked ones
   assign wr_lock_eff = write_protect_blocks_q | ~BLK_MASK;
   assign rd_lock_eff = table_read_protect_blocks_q | ~BLK_MASK;

   // Boot size frozen when any boot or block 0 protection is on
   // Any of these at zero freezes the field, so a protected boot
   // region cannot be resized to expose or shift protected code
   assign boot_size_locked = !boot_code_protect || !block0_code_protect ||
      !boot_write_lock || !wr_lock_eff[0] ||
      !boot_read_lock || !rd_lock_eff[0];

   // Config writes only in programming and while unlocked
   // Running code never rewrites configuration through this port
   assign cfg_write_allowed = (mode_q != cfgp_pkg::CFGP_RUN) && config_write_lock;

   // Identification word, never masked by protection
   assign part_revision_byte = {PART_CODE, REV_CODE};
   assign part_family_byte = FAMILY_CODE;

   // Boot block end grows with the size field, widest at code 2
   // Size code 3, the erased value, acts as code 2
   always_comb begin
      case (boot_size_field)
         2'b00: boot_hi = `CFGP_BOOT_UNIT - 22'h000001;
         2'b01: boot_hi = (`CFGP_BOOT_UNIT << 1) - 22'h000001;
         default: boot_hi = (`CFGP_BOOT_UNIT << 2) - 22'h000001;
      endcase
   end

   // Block bounds and lock bits for every guard
   always_comb begin
      grd_lo[0] = 22'h000000;
      grd_hi[0] = boot_hi;
      grd_wr_open[0] = boot_write_lock;
      grd_rd_open[0] = boot_read_lock;
      for (int i = 1; i < NG; i++) begin
         grd_lo[i] = (i == 1) ? boot_hi + 22'h000001 : 22'((i - 1) * `CFGP_BLOCK_SIZE);
         grd_hi[i] = 22'(i * `CFGP_BLOCK_SIZE) - 22'h000001;
         grd_wr_open[i] = wr_lock_eff[i-1];
         grd_rd_open[i] = rd_lock_eff[i-1];
      end
   end

   // One guard per code block
   // The boot guard sits at index 0, so block n uses guard n+1
   // and lock bit n of the block lock bytes
   for (genvar g = 0; g < NG; g++) begin : gen_guard
      cfgp_block_guard #(
         .AW(`CFGP_AW)
      ) u_guard (
         .i_addr(i_code_addr),
         .i_exec_addr(i_exec_addr),
         .i_lo(grd_lo[g]),
         .i_hi(grd_hi[g]),
         .i_wr_open(grd_wr_open[g]),
         .i_rd_open(grd_rd_open[g]),
         .o_hit(grd_hit[g]),
         .o_wr_ok(grd_wr_ok[g]),
         .o_rd_ok(grd_rd_ok[g])
      );
   end

   // Suppress forbidden accesses; addresses past the last block never pass
   // Verdicts only read the stored bytes, so a refused access
   // can never disturb configuration contents
   assign o_code_wr_ok = i_code_wr_req && (|grd_wr_ok);
   assign o_code_rd_ok = i_code_rd_req && (|grd_rd_ok);
   assign o_data_wr_ok = i_data_wr_req && data_mem_write_lock;

   // Next programming mode
   // High voltage wins over the entry pin in every state, so a part
   // with low-voltage entry disabled can always be recovered
   // Dropping the high voltage always returns to normal running
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         cfgp_pkg::CFGP_RUN: begin
            if (i_high_entry_voltage) begin
               mode_d = cfgp_pkg::CFGP_HV_PROG;
            end else if (i_prog_entry_pin && low_voltage_prog_enable) begin
               mode_d = cfgp_pkg::CFGP_LV_PROG;
            end
         end
         cfgp_pkg::CFGP_LV_PROG: begin
            if (i_high_entry_voltage) begin
               mode_d = cfgp_pkg::CFGP_HV_PROG;
            end else if (!i_prog_entry_pin) begin
               mode_d = cfgp_pkg::CFGP_RUN;
            end
         end
         cfgp_pkg::CFGP_HV_PROG: begin
            if (!i_high_entry_voltage) begin
               mode_d = cfgp_pkg::CFGP_RUN;
            end
         end
         default: mode_d = cfgp_pkg::CFGP_RUN;
      endcase
   end

   // Mode register
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         mode_q <= cfgp_pkg::CFGP_RUN;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Mode outputs
   assign o_prog_active = (mode_q != cfgp_pkg::CFGP_RUN);
   assign o_prog_high_voltage = (mode_q == cfgp_pkg::CFGP_HV_PROG);
   // Pin is I/O only with enable cleared and never in low-voltage mode
   // Low-voltage mode keeps the pin dedicated until the mode is left
   assign o_prog_entry_pin_gpio = !low_voltage_prog_enable &&
      (mode_q != cfgp_pkg::CFGP_LV_PROG);
   assign o_boot_size_field = {1'b0, boot_size_field};

   // Configuration bytes; erased factory state is all ones
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         debug_lvp_config_low_q <= `CFGP_ERASED;
         code_protect_low_q <= `CFGP_ERASED;
         code_protect_high_q <= `CFGP_ERASED;
         write_protect_blocks_q <= `CFGP_ERASED;
         write_protect_special_q <= `CFGP_ERASED;
         table_read_protect_blocks_q <= `CFGP_ERASED;
         table_read_protect_special_q <= `CFGP_ERASED;
      end else if (i_cfg_we && cfg_write_allowed) begin
         if (i_cfg_addr == `CFGP_ADDR_CFG4L) begin
            // Enable bit keeps its value outside high-voltage entry
            if (mode_q == cfgp_pkg::CFGP_HV_PROG) begin
               debug_lvp_config_low_q[`CFGP_LV_EN_BIT] <= i_cfg_wdata[`CFGP_LV_EN_BIT];
            end
            // Frozen size bits are ignored, not refused; the write still
            // acknowledges so the other bits of the byte can change
            if (!boot_size_locked) begin
               debug_lvp_config_low_q[`CFGP_BOOT_SIZE_LSB +: 2] <=
                  i_cfg_wdata[`CFGP_BOOT_SIZE_LSB +: 2];
            end
            debug_lvp_config_low_q[1:0] <= i_cfg_wdata[1:0];
            debug_lvp_config_low_q[3] <= i_cfg_wdata[3];
            debug_lvp_config_low_q[7:6] <= i_cfg_wdata[7:6];
         end else if (i_cfg_addr == `CFGP_ADDR_CFG5L) begin
            code_protect_low_q <= i_cfg_wdata;
         end else if (i_cfg_addr == `CFGP_ADDR_CFG5H) begin
            code_protect_high_q <= i_cfg_wdata;
         end else if (i_cfg_addr == `CFGP_ADDR_CFG6L) begin
            write_protect_blocks_q <= i_cfg_wdata | ~BLK_MASK;
         end else if (i_cfg_addr == `CFGP_ADDR_CFG6H) begin
            write_protect_special_q <= i_cfg_wdata;
         end else if (i_cfg_addr == `CFGP_ADDR_CFG7L) begin
            table_read_protect_blocks_q <= i_cfg_wdata | ~BLK_MASK;
         end else if (i_cfg_addr == `CFGP_ADDR_CFG7H) begin
            table_read_protect_special_q <= i_cfg_wdata;
         end
      end
   end

   // Write answer: accepted or refused, one cycle after the strobe
   // A held strobe is answered once for every edge that takes it
   // Refusal leaves every stored byte as it was
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_wack_q <= 1'b0;
         cfg_wrefused_q <= 1'b0;
      end else begin
         cfg_wack_q <= i_cfg_we && cfg_write_allowed;
         cfg_wrefused_q <= i_cfg_we && !cfg_write_allowed;
      end
   end

   // Read decode; identification is never gated
   // Block lock bytes read back with absent blocks forced open
   // Unmapped addresses answer zero rather than stale data
   always_comb begin
      if (i_cfg_addr == `CFGP_ADDR_ID_LO) begin
         cfg_rdata_d = part_revision_byte;
      end else if (i_cfg_addr == `CFGP_ADDR_ID_HI) begin
         cfg_rdata_d = part_family_byte;
      end else if (i_cfg_addr == `CFGP_ADDR_CFG4L) begin
         cfg_rdata_d = debug_lvp_config_low_q;
      end else if (i_cfg_addr == `CFGP_ADDR_CFG5L) begin
         cfg_rdata_d = code_protect_low_q;
      end else if (i_cfg_addr == `CFGP_ADDR_CFG5H) begin
         cfg_rdata_d = code_protect_high_q;
      end else if (i_cfg_addr == `CFGP_ADDR_CFG6L) begin
         cfg_rdata_d = wr_lock_eff;
      end else if (i_cfg_addr == `CFGP_ADDR_CFG6H) begin
         cfg_rdata_d = write_protect_special_q;
      end else if (i_cfg_addr == `CFGP_ADDR_CFG7L) begin
         cfg_rdata_d = rd_lock_eff;
      end else if (i_cfg_addr == `CFGP_ADDR_CFG7H) begin
         cfg_rdata_d = table_read_protect_special_q;
      end else begin
         cfg_rdata_d = `CFGP_UNMAPPED;
      end
   end

   // Read data and valid, one cycle after the strobe
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_rdata_q <= 8'h00;
         cfg_rvalid_q <= 1'b0;
      end else begin
         cfg_rvalid_q <= i_cfg_re;
         if (i_cfg_re) begin
            cfg_rdata_q <= cfg_rdata_d;
         end
      end
   end

   // Programmer port outputs
   assign o_cfg_rdata = cfg_rdata_q;
   assign o_cfg_rvalid = cfg_rvalid_q;
   assign o_cfg_wack = cfg_wack_q;
   assign o_cfg_wrefused = cfg_wrefused_q;

endmodule

// ===== verification/cfgp_chk.sv
// Port checker for the configuration protection block.
// Bound to every instance of the block by the statement at the foot.
`timescale 1ns/1ps
module cfgp_chk #(
   parameter int NUM_BLOCKS = 4,
   parameter logic [7:0] FAMILY_CODE = 8'h5A,
   parameter logic [2:0] PART_CODE = 3'h5,
   parameter logic [4:0] REV_CODE = 5'h01
) (
   // Clock, reset, entry level
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_high_entry_voltage,
   // Programmer port
   input wire logic i_cfg_we,
   input wire logic i_cfg_re,
   input wire logic [21:0] i_cfg_addr,
   input wire logic [7:0] o_cfg_rdata,
   input wire logic o_cfg_rvalid,
   input wire logic o_cfg_wack,
   input wire logic o_cfg_wrefused,
   // Core checks and mode
   input wire logic [21:0] i_code_addr,
   input wire logic o_code_wr_ok,
   input wire logic o_code_rd_ok,
   input wire logic o_prog_active,
   input wire logic o_prog_high_voltage,
   input wire logic o_prog_entry_pin_gpio
);
   // First address past the last present block
   localparam logic [21:0] END_ADDR = 22'(NUM_BLOCKS * 16384);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   // Answers one cycle after the taking edge
   AST_RVALID: assert property (i_cfg_re |=> o_cfg_rvalid)
      else $error("read not answered next cycle");
   AST_WANSWER: assert property (i_cfg_we |=> (o_cfg_wack ^ o_cfg_wrefused))
      else $error("write not answered exactly once");
   AST_RUN_REFUSE: assert property (i_cfg_we && !o_prog_active |=> o_cfg_wrefused)
      else $error("write outside programming not refused");
   AST_ID_LO: assert property (i_cfg_re && i_cfg_addr == 22'h3FFFFE
      |=> o_cfg_rdata == {PART_CODE, REV_CODE}) else $error("identification low byte wrong");
   AST_ID_HI: assert property (i_cfg_re && i_cfg_addr == 22'h3FFFFF
      |=> o_cfg_rdata == FAMILY_CODE) else $error("identification high byte wrong");
   // Absent blocks never open
   AST_PAST_END: assert property (i_code_addr >= END_ADDR |-> !o_code_wr_ok && !o_code_rd_ok)
      else $error("access past last block allowed");
   AST_HV_ENTRY: assert property (i_high_entry_voltage |=> o_prog_high_voltage)
      else $error("high voltage entry not honoured");
   AST_LV_PIN: assert property (o_prog_active && !o_prog_high_voltage
      |-> !o_prog_entry_pin_gpio) else $error("entry pin free in low voltage mode");
   // Main scenarios
   COV_REFUSE: cover property (o_cfg_wrefused);
   COV_LV: cover property (o_prog_active && !o_prog_high_voltage);
   COV_GPIO: cover property (o_prog_entry_pin_gpio);
endmodule

bind cfgp_config_protect cfgp_chk #(.NUM_BLOCKS(NUM_BLOCKS), .FAMILY_CODE(FAMILY_CODE),
   .PART_CODE(PART_CODE), .REV_CODE(REV_CODE)) cfgp_chk_inst (.i_mclk(i_mclk),
   .i_nrst(i_nrst), .i_high_entry_voltage(i_high_entry_voltage), .i_cfg_we(i_cfg_we),
   .i_cfg_re(i_cfg_re), .i_cfg_addr(i_cfg_addr), .o_cfg_rdata(o_cfg_rdata),
   .o_cfg_rvalid(o_cfg_rvalid), .o_cfg_wack(o_cfg_wack), .o_cfg_wrefused(o_cfg_wrefused),
   .i_code_addr(i_code_addr), .o_code_wr_ok(o_code_wr_ok), .o_code_rd_ok(o_code_rd_ok),
   .o_prog_active(o_prog_active), .o_prog_high_voltage(o_prog_high_voltage),
   .o_prog_entry_pin_gpio(o_prog_entry_pin_gpio));

// ===== verification/cfgp_prog_model.sv
// Programmer model: entry levels and single-byte strobes.
// Drives at the falling edge; answers are taken one cycle after.
`timescale 1ns/1ps
module cfgp_prog_model (
   // Clock and answers
   input wire logic i_mclk,
   input wire logic [7:0] i_rdata,
   input wire logic i_rvalid,
   input wire logic i_wack,
   input wire logic i_wrefused,
   // Entry levels and strobes
   output logic o_hv,
   output logic o_pin,
   output logic o_we,
   output logic o_re,
   output logic [21:0] o_addr,
   output logic [7:0] o_wdata
);
   // Image base addresses the programmer files contents under
   localparam logic [23:0] IMG_CFG_BASE = 24'h300000;
   localparam logic [23:0] IMG_DATA_BASE = 24'hF00000;
   // Idle from time zero
   initial begin
      o_hv = 1'b0;
      o_pin = 1'b0;
      o_we = 1'b0;
      o_re = 1'b0;
      o_addr = 22'h000000;
      o_wdata = 8'h00;
   end
   // Entry levels, held until changed
   task automatic entry(input logic hv, input logic pin);
      @(negedge i_mclk);
      o_hv = hv;
      o_pin = pin;
   endtask
   // One byte write; released data shows the inverse
   task automatic wr(input logic [21:0] a, input logic [7:0] d, output logic ack,
                     output logic rf);
      @(negedge i_mclk);
      o_we = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(negedge i_mclk);
      o_we = 1'b0;
      o_wdata = ~d;
      ack = i_wack;
      rf = i_wrefused;
   endtask
   // One byte read
   task automatic rd(input logic [21:0] a, output logic [7:0] d, output logic v);
      @(negedge i_mclk);
      o_re = 1'b1;
      o_addr = a;
      @(negedge i_mclk);
      o_re = 1'b0;
      d = i_rdata;
      v = i_rvalid;
   endtask
endmodule

// ===== verification/tb.sv
// Testbench for the configuration protection block.
// Programmer model drives the port; core checks are driven here.
`timescale 1ns/1ps
module tb;
   logic i_mclk, i_nrst, code_wr, code_rd, data_wr, hv, pin, we, re, rvalid, wack, wref;
   logic wr_ok, rd_ok, d_ok, act, hvm, gpio;
   logic [21:0] code_addr, exec_addr, addr;
   logic [7:0] wdata, rdata;
   logic [2:0] bsz;
   int fail_count, n_checks;
   // Clock, 50 ns period
   always #25 i_mclk = ~i_mclk;
   cfgp_prog_model cfgp_prog_model_inst (.i_mclk(i_mclk), .i_rdata(rdata), .i_rvalid(rvalid),
      .i_wack(wack), .i_wrefused(wref), .o_hv(hv), .o_pin(pin), .o_we(we), .o_re(re),
      .o_addr(addr), .o_wdata(wdata));
   cfgp_config_protect cfgp_config_protect_inst (.i_mclk(i_mclk), .i_nrst(i_nrst),
      .i_high_entry_voltage(hv), .i_prog_entry_pin(pin), .i_cfg_we(we), .i_cfg_re(re),
      .i_cfg_addr(addr), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
      .o_cfg_wack(wack), .o_cfg_wrefused(wref), .i_code_wr_req(code_wr),
      .i_code_rd_req(code_rd), .i_code_addr(code_addr), .i_exec_addr(exec_addr),
      .o_code_wr_ok(wr_ok), .o_code_rd_ok(rd_ok), .i_data_wr_req(data_wr),
      .o_data_wr_ok(d_ok), .o_prog_active(act), .o_prog_high_voltage(hvm),
      .o_prog_entry_pin_gpio(gpio), .o_boot_size_field(bsz));
   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Write, expect accept or refusal
   task automatic wchk(input logic [21:0] a, input logic [7:0] d, input logic ok);
      logic ack, rf;
      cfgp_prog_model_inst.wr(a, d, ack, rf);
      chk({6'h00, ack, rf}, {6'h00, ok, !ok});
   endtask
   task automatic rchk(input logic [21:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      cfgp_prog_model_inst.rd(a, d, v);
      chk({7'h00, v}, 8'h01);
      chk(d, exp);
   endtask
   // Core requests: expect {code write, table read, data write}
   task automatic code(input logic [21:0] a, input logic [21:0] x, input logic [2:0] exp);
      @(negedge i_mclk);
      code_addr = a;
      exec_addr = x;
      #1;
      chk({5'h00, wr_ok, rd_ok, d_ok}, {5'h00, exp});
   endtask
   // Entry change; expect {active, high voltage, gpio} one edge later
   task automatic mode(input logic h, input logic p, input logic [2:0] exp);
      cfgp_prog_model_inst.entry(h, p);
      @(negedge i_mclk);
      chk({5'h00, act, hvm, gpio}, {5'h00, exp});
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      #(2000 * 50);
      fail_count++;
      summarize();
   end
   // Test sequence
   initial begin
      i_mclk = 1'b0;
      i_nrst = 1'b0;
      code_wr = 1'b1;
      code_rd = 1'b1;
      data_wr = 1'b1;
      code_addr = 22'h000000;
      exec_addr = 22'h000000;
      repeat (3) @(negedge i_mclk);
      i_nrst = 1'b1;
      rchk(22'h3FFFFE, 8'hA1);
      rchk(22'h3FFFFF, 8'h5A);
      rchk(22'(cfgp_prog_model_inst.IMG_CFG_BASE + 24'h000006), 8'hFF);
      rchk(22'h30000A, 8'hFF);
      rchk(22'h30000B, 8'hFF);
      rchk(22'h30000C, 8'hFF);
      rchk(22'h300010, 8'h00);
      chk({5'h00, bsz}, 8'h03);
      wchk(22'h30000A, 8'h00, 1'b0);
      $display("test reset done");
      mode(1'b0, 1'b1, 3'b100);
      wchk(22'h300006, 8'hFB, 1'b1);
      rchk(22'h300006, 8'hFF);
      mode(1'b0, 1'b0, 3'b000);
      $display("test low voltage done");
      mode(1'b1, 1'b0, 3'b110);
      wchk(22'h300006, 8'hCB, 1'b1);
      rchk(22'h300006, 8'hCB);
      chk({5'h00, bsz}, 8'h00);
      wchk(22'h30000A, 8'hFE, 1'b1);
      wchk(22'h300006, 8'hFB, 1'b1);
      rchk(22'h300006, 8'hCB);
      code(22'h002000, 22'h002000, 3'b011);
      code(22'h004000, 22'h000000, 3'b111);
      wchk(22'h30000B, 8'h3F, 1'b1);
      code(22'h000100, 22'h000100, 3'b010);
      wchk(22'h30000C, 8'hFD, 1'b1);
      code(22'h004000, 22'h008000, 3'b100);
      code(22'h004000, 22'h004100, 3'b110);
      code(22'h010000, 22'h010000, 3'b000);
      // Dropped requests never pass, even into open blocks
      code_wr = 1'b0;
      code_rd = 1'b0;
      code(22'h004000, 22'h004100, 3'b000);
      code_wr = 1'b1;
      code_rd = 1'b1;
      $display("test locks done");
      mode(1'b0, 1'b0, 3'b001);
      mode(1'b0, 1'b1, 3'b001);
      mode(1'b1, 1'b1, 3'b111);
      wchk(22'h300008, 8'hFE, 1'b1);
      wchk(22'h30000B, 8'h1F, 1'b1);
      wchk(22'h30000A, 8'hFF, 1'b0);
      rchk(22'h30000A, 8'hFE);
      rchk(22'h3FFFFE, 8'hA1);
      rchk(22'h3FFFFF, 8'h5A);
      $display("test config lock done");
      summarize();
   end
endmodule
